// >>> rtl/tfm_defs.vh
// tfm_defs.vh: offsets, codes, field positions and reset values of the terminal function mapper
// assumes inclusion by bare name from every design file that needs them
`ifndef TFM_DEFS_VH
`define TFM_DEFS_VH

// ==========================================================
// register offsets (register index on the plain port)
`define TFM_ADR_IN_BASE 8'h00
`define TFM_ADR_OUT_FIRST 8'h10
`define TFM_ADR_OUT_SECOND 8'h11
`define TFM_ADR_OUT_RELAY 8'h12
`define TFM_ADR_STATUS 8'h20
`define TFM_ADR_CTRL 8'h21

// ==========================================================
// input function codes
`define TFM_FN_DROOP 8'h4C
`define TFM_FN_GAIN_LO 8'h4E
`define TFM_FN_GAIN_HI 8'h4F
`define TFM_FN_LOGIC_CANCEL 8'h50
`define TFM_FN_TIMER_CLEAR 8'h51
`define TFM_FN_REGEN_CANCEL 8'h52
`define TFM_FN_RUN_FORWARD 8'h62
`define TFM_FN_RUN_BACKWARD 8'h63
`define TFM_FN_NONE 8'h64
`define TFM_FN_PID_LO 8'hAB
`define TFM_FN_PID_HI 8'hAC

// ==========================================================
// output codes and polarity
`define TFM_OUT_INV_OFFSET 11'h3E8
`define TFM_OUT_MAX_CODE 11'h01F
`define TFM_OUT_VALID_MASK 32'h7E7F85FF
`define TFM_CODE_UNDERVOLT 5'h03
`define TFM_CODE_PREWARN 5'h07
`define TFM_CODE_READY 5'h0A
`define TFM_CODE_STAGE1 5'h12
`define TFM_CODE_STAGE2 5'h13
`define TFM_CODE_STAGE4 5'h14
`define TFM_CODE_FAN 5'h19
`define TFM_CODE_HEATSINK 5'h1C
`define TFM_CODE_PHASE_LOCK 5'h1D

// ==========================================================
// control modes
`define TFM_MODE_PG_VF 3'h1
`define TFM_MODE_IM_CLV 3'h2

// ==========================================================
// reset values (all normal polarity)
`define TFM_RST_OUT_FIRST 11'h000
`define TFM_RST_OUT_SECOND 11'h001
`define TFM_RST_OUT_RELAY 11'h00A
`define TFM_RST_IN_GENERAL 8'h64
`define TFM_RST_IN_SLOT_A 8'h62
`define TFM_RST_IN_SLOT_B 8'h63

// ==========================================================
// status and control fields
`define TFM_ST_ERR_BIT 15
`define TFM_CTRL_ERR_CLR_BIT 0

`endif

// >>> rtl/tfm_in_sync.v
// tfm_in_sync.v: three-stage synchroniser for the digital input terminal pins
// assumes asynchronous pins; a change is taken once stages two and three agree
`timescale 1ns/10ps

module tfm_in_sync #(
	parameter WIDTH = 7
) (
	input wire ref_clk,
	input wire resetn,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] level_out
);

// ==========================================================
// per-bit synchroniser and agreement filter
genvar gi;
generate
	for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
		reg s1_q;
		reg s2_q;
		reg s3_q;
		reg lvl_q;
		// first stage feeds only the second, so no logic sees a metastable value
		always @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				lvl_q <= 1'b0;
			end else begin
				s1_q <= pin_in[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					lvl_q <= s3_q; // glitch of one cycle never reaches the level
				end
			end
		end
		assign level_out[gi] = lvl_q;
	end
endgenerate

endmodule // tfm_in_sync

// >>> rtl/tfm_out_sel.v
// tfm_out_sel.v: decodes one output assignment code into a terminal level
// assumes the status vector is on the same clock; the level is registered
`timescale 1ns/10ps
`include "tfm_defs.vh"

module tfm_out_sel (
	input wire ref_clk,
	input wire resetn,
	input wire [10:0] code,
	input wire [31:0] sig_vec,
	output reg term_q
);

reg inv;
reg [10:0] base;
reg valid;
reg term_d;

// defined codes one bit each; a bare literal cannot be indexed
localparam [31:0] VALID_MASK = `TFM_OUT_VALID_MASK;

// ==========================================================
// split polarity from signal code, drop undefined codes
always @* begin
	inv = (code >= `TFM_OUT_INV_OFFSET);
	base = inv ? (code - `TFM_OUT_INV_OFFSET) : code;
	valid = (base <= `TFM_OUT_MAX_CODE) && VALID_MASK[base[4:0]];
	// undefined code holds the terminal off whatever the polarity
	term_d = valid & (sig_vec[base[4:0]] ^ inv);
end

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		term_q <= 1'b0;
	end else begin
		term_q <= term_d;
	end
end

endmodule // tfm_out_sel

// >>> rtl/tfm_top.v
// tfm_top.v: terminal function mapper of a motor drive
// maps input terminals to command functions and status signals to output terminals
// assumes status inputs on ref_clk, terminal pins asynchronous, plain register port
//
// Behaviour
// - droop function input on enables droop control, off disables it.
// - two speed gain select inputs pick one of four speed parameter sets.
// - logic engine cancel input halts the customizable logic while asserted.
// - logic timer clear input resets all customizable logic timers.
// - regen avoid cancel input on disables anti-regenerative control.
// - two PID setpoint select inputs pick one of four preset PID commands.
// - forward run on drives forward; off decelerates to stop.
// - backward run on drives reverse; off decelerates to stop.
// - forward and backward run only accepted on the two dedicated input slots.
// - unassigned input does nothing but stays visible to the customizable logic.
// - each output assignment selects the status signal driving its terminal.
// - code of 1000 or more selects inverted signal of code minus 1000.
// - after reset every output assignment has normal polarity.
// - normal polarity alarm energizes relay: normally open closes, normally closed opens.
// - inverted polarity alarm de-energizes relay: normally open opens, normally closed closes.
// - code 10 shows ready to drive, 1010 its inverse.
// - code 3 shows stopped by undervoltage, 1003 its inverse.
// - codes 18, 19, 20 show the stage number weights one, two, four.
// - code 25 shows cooling fan running, 1025 its inverse.
// - code 28 shows heat sink overtemperature early warning, 1028 its inverse.
// - code 7 shows motor overload early warning, 1007 its inverse.
// - code 29 phase lock done only in encoder V/f and closed-loop vector.
`timescale 1ns/10ps
`include "tfm_defs.vh"

module tfm_top #(
	parameter NUM_IN = 7
) (
	input wire ref_clk,
	input wire resetn,
	// register port
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// digital input terminals; the top two are input_slot_a and input_slot_b
	input wire [NUM_IN-1:0] din_pins,
	// internal status sources
	input wire [2:0] control_mode,
	input wire [31:0] status_aux,
	input wire undervolt_stopped_flag,
	input wire motor_thermal_prewarn,
	input wire ready_to_drive,
	input wire [2:0] stage_number,
	input wire fan_running,
	input wire heatsink_overtemp_warning,
	input wire phase_lock_done,
	// command functions
	output reg droop_enable,
	output reg [1:0] speed_gain_set,
	output reg logic_engine_cancel,
	output reg logic_timer_clear,
	output reg regen_avoid_cancel,
	output reg [1:0] pid_setpoint_sel,
	output reg drive_forward,
	output reg drive_reverse,
	output reg decel_to_stop,
	output wire [NUM_IN-1:0] logic_src,
	// output terminals
	output wire transistor_out_one,
	output wire transistor_out_two,
	output wire relay_coil,
	output reg relay_no_closed,
	output reg relay_nc_closed
);

localparam SLOT_A = NUM_IN - 2;
localparam SLOT_B = NUM_IN - 1;

// ==========================================================
// input pin synchroniser
// three stages cost latency but keep a slow pin edge from being seen twice
wire [NUM_IN-1:0] din_lvl;

tfm_in_sync #(
	.WIDTH(NUM_IN)
) u_sync (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.pin_in(din_pins),
	.level_out(din_lvl)
);

// every synchronised level goes to the customizable logic, assigned or not
assign logic_src = din_lvl;

// ==========================================================
// assignment registers
// register map, one 16-bit word per index:
//   0x00..0x06 input assignment, function code in [7:0]
//   0x05 and 0x06 are the dedicated run slots
//   0x10 first transistor output code in [10:0]
//   0x11 second transistor output code in [10:0]
//   0x12 relay output code in [10:0]
//   0x20 status, read only
//     [6:0] synchronised input levels
//     [8] first transistor, [9] second transistor, [10] relay coil
//     [11] forward run, [12] backward run, [15] refusal flag
//   0x21 control, write only, [0] clears the refusal flag
// unmapped indices read as zero and ignore writes
// output codes of 1000 and up select the inverted signal
// a refused write keeps the old code, so software should read back
reg [7:0] in_assign_q [0:NUM_IN-1];
reg [10:0] out_first_q;
reg [10:0] out_second_q;
reg [10:0] out_relay_q;
reg assign_err_q;
reg assign_err_d;

wire wr_in_hit = reg_wr && (reg_addr < NUM_IN);
wire wdata_is_run = (reg_wdata[7:0] == `TFM_FN_RUN_FORWARD) || (reg_wdata[7:0] == `TFM_FN_RUN_BACKWARD);
wire run_on_slot = (reg_addr == SLOT_A) || (reg_addr == SLOT_B);
// run functions on a general input are refused and flagged
wire wr_refused = wr_in_hit && wdata_is_run && !run_on_slot;

genvar gi;
generate
	for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_in_reg
		always @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				if (gi == SLOT_A) begin
					in_assign_q[gi] <= `TFM_RST_IN_SLOT_A;
				end else if (gi == SLOT_B) begin
					in_assign_q[gi] <= `TFM_RST_IN_SLOT_B;
				end else begin
					in_assign_q[gi] <= `TFM_RST_IN_GENERAL;
				end
			end else if (wr_in_hit && (reg_addr == gi) && !wr_refused) begin
				in_assign_q[gi] <= reg_wdata[7:0];
			end
		end
	end
endgenerate

// output assignments come out of reset in normal polarity
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		out_first_q <= `TFM_RST_OUT_FIRST;
		out_second_q <= `TFM_RST_OUT_SECOND;
		out_relay_q <= `TFM_RST_OUT_RELAY;
	end else if (reg_wr) begin
		if (reg_addr == `TFM_ADR_OUT_FIRST) begin
			out_first_q <= reg_wdata[10:0];
		end
		if (reg_addr == `TFM_ADR_OUT_SECOND) begin
			out_second_q <= reg_wdata[10:0];
		end
		if (reg_addr == `TFM_ADR_OUT_RELAY) begin
			out_relay_q <= reg_wdata[10:0];
		end
	end
end

// refusal flag: a new refusal in the clearing cycle wins over the clear
// software sees it in status bit 15 and clears it through control bit 0
always @* begin
	assign_err_d = assign_err_q;
	if (reg_wr && (reg_addr == `TFM_ADR_CTRL) && reg_wdata[`TFM_CTRL_ERR_CLR_BIT]) begin
		assign_err_d = 1'b0;
	end
	if (wr_refused) begin
		assign_err_d = 1'b1;
	end
end

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		assign_err_q <= 1'b0;
	end else begin
		assign_err_q <= assign_err_d;
	end
end

// ==========================================================
// input function decode
// a function assigned to several inputs is the OR of all of them
reg [NUM_IN-1:0] hit_droop;
reg [NUM_IN-1:0] hit_gain_lo;
reg [NUM_IN-1:0] hit_gain_hi;
reg [NUM_IN-1:0] hit_cancel;
reg [NUM_IN-1:0] hit_tclr;
reg [NUM_IN-1:0] hit_regen;
reg [NUM_IN-1:0] hit_pid_lo;
reg [NUM_IN-1:0] hit_pid_hi;
reg [NUM_IN-1:0] hit_forward;
reg [NUM_IN-1:0] hit_backward;
integer k;

// an active terminal drives only the function it is assigned; code none matches nothing
always @* begin
	hit_droop = {NUM_IN{1'b0}};
	hit_gain_lo = {NUM_IN{1'b0}};
	hit_gain_hi = {NUM_IN{1'b0}};
	hit_cancel = {NUM_IN{1'b0}};
	hit_tclr = {NUM_IN{1'b0}};
	hit_regen = {NUM_IN{1'b0}};
	hit_pid_lo = {NUM_IN{1'b0}};
	hit_pid_hi = {NUM_IN{1'b0}};
	hit_forward = {NUM_IN{1'b0}};
	hit_backward = {NUM_IN{1'b0}};
	for (k = 0; k < NUM_IN; k = k + 1) begin
		hit_droop[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_DROOP);
		hit_gain_lo[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_GAIN_LO);
		hit_gain_hi[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_GAIN_HI);
		hit_cancel[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_LOGIC_CANCEL);
		hit_tclr[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_TIMER_CLEAR);
		hit_regen[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_REGEN_CANCEL);
		hit_pid_lo[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_PID_LO);
		hit_pid_hi[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_PID_HI);
		// run codes only count on the dedicated slots, guarding against stale values
		if ((k == SLOT_A) || (k == SLOT_B)) begin
			hit_forward[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_RUN_FORWARD);
			hit_backward[k] = din_lvl[k] && (in_assign_q[k] == `TFM_FN_RUN_BACKWARD);
		end
	end
end

// registered command outputs; both run commands on together means stop
// timer clear is a level: the logic engine holds its timers while it stands
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		droop_enable <= 1'b0;
		speed_gain_set <= 2'h0;
		logic_engine_cancel <= 1'b0;
		logic_timer_clear <= 1'b0;
		regen_avoid_cancel <= 1'b0;
		pid_setpoint_sel <= 2'h0;
		drive_forward <= 1'b0;
		drive_reverse <= 1'b0;
		decel_to_stop <= 1'b1;
	end else begin
		droop_enable <= |hit_droop;
		speed_gain_set <= {|hit_gain_hi, |hit_gain_lo};
		logic_engine_cancel <= |hit_cancel;
		logic_timer_clear <= |hit_tclr;
		regen_avoid_cancel <= |hit_regen;
		pid_setpoint_sel <= {|hit_pid_hi, |hit_pid_lo};
		drive_forward <= (|hit_forward) && !(|hit_backward);
		drive_reverse <= (|hit_backward) && !(|hit_forward);
		decel_to_stop <= !((|hit_forward) ^ (|hit_backward));
	end
end

// ==========================================================
// status vector indexed by output code
// unnamed codes come straight from status_aux; named ports override their bits
reg [31:0] sig_vec;
wire lock_mode_ok = (control_mode == `TFM_MODE_PG_VF) || (control_mode == `TFM_MODE_IM_CLV);

always @* begin
	sig_vec = status_aux;
	sig_vec[`TFM_CODE_UNDERVOLT] = undervolt_stopped_flag;
	sig_vec[`TFM_CODE_PREWARN] = motor_thermal_prewarn;
	sig_vec[`TFM_CODE_READY] = ready_to_drive;
	sig_vec[`TFM_CODE_STAGE1] = stage_number[0];
	sig_vec[`TFM_CODE_STAGE2] = stage_number[1];
	sig_vec[`TFM_CODE_STAGE4] = stage_number[2];
	sig_vec[`TFM_CODE_FAN] = fan_running;
	sig_vec[`TFM_CODE_HEATSINK] = heatsink_overtemp_warning;
	// outside the two encoder modes the lock signal is meaningless, so force it off
	sig_vec[`TFM_CODE_PHASE_LOCK] = phase_lock_done && lock_mode_ok;
end

// ==========================================================
// output terminal selectors
// one registered selector per terminal, so all terminals switch on one edge
tfm_out_sel u_sel_first (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.code(out_first_q),
	.sig_vec(sig_vec),
	.term_q(transistor_out_one)
);

tfm_out_sel u_sel_second (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.code(out_second_q),
	.sig_vec(sig_vec),
	.term_q(transistor_out_two)
);

tfm_out_sel u_sel_relay (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.code(out_relay_q),
	.sig_vec(sig_vec),
	.term_q(relay_coil)
);

// contact pairs follow the coil; in negative logic an alarm drops the coil
// a lost coil supply opens the make pair, so negative logic fails safe
always @* begin
	relay_no_closed = relay_coil;
	relay_nc_closed = !relay_coil;
end

// ==========================================================
// register read port, data one cycle after the strobe
// zero outside the answer cycle, so a stale word is never read twice
reg [15:0] rd_mux;

always @* begin
	rd_mux = 16'h0000;
	if (reg_addr < NUM_IN) begin
		rd_mux = {8'h00, in_assign_q[reg_addr[2:0]]};
	end else begin
		case (reg_addr)
			`TFM_ADR_OUT_FIRST: rd_mux = {5'h00, out_first_q};
			`TFM_ADR_OUT_SECOND: rd_mux = {5'h00, out_second_q};
			`TFM_ADR_OUT_RELAY: rd_mux = {5'h00, out_relay_q};
			`TFM_ADR_STATUS: begin
				rd_mux[NUM_IN-1:0] = din_lvl;
				rd_mux[8] = transistor_out_one;
				rd_mux[9] = transistor_out_two;
				rd_mux[10] = relay_coil;
				rd_mux[11] = drive_forward;
				rd_mux[12] = drive_reverse;
				rd_mux[`TFM_ST_ERR_BIT] = assign_err_q;
			end
			default: rd_mux = 16'h0000; // unmapped reads as zero
		endcase
	end
end

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		reg_rdata <= 16'h0000;
	end else if (reg_rd) begin
		reg_rdata <= rd_mux;
	end else begin
		reg_rdata <= 16'h0000;
	end
end

endmodule // tfm_top

// >>> sim/tfm_checker.sv
// tfm_checker.sv: concurrent checks on the ports of the terminal function mapper
// assumes a bind onto tfm_top and the register offsets of tfm_defs.vh
`timescale 1ns/10ps
`include "tfm_defs.vh"

module tfm_checker #(
	parameter NUM_IN = 7
) (
	input wire ref_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire [2:0] control_mode,
	input wire undervolt_stopped_flag,
	input wire ready_to_drive,
	input wire drive_forward,
	input wire drive_reverse,
	input wire decel_to_stop,
	input wire relay_coil,
	input wire relay_no_closed,
	input wire relay_nc_closed
);
	// ==========================================================
	// relay assignment mirror
	reg [10:0] relay_code_q;

	// shadow of the relay code so checks know which source should drive the coil
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			relay_code_q <= `TFM_RST_OUT_RELAY;
		else if (reg_wr && reg_addr == `TFM_ADR_OUT_RELAY)
			relay_code_q <= reg_wdata[10:0];
	end

	// ==========================================================
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// inverted undervoltage code written alone, with no second write behind it
	sequence s_relay_inv_uv;
		reg_wr && reg_addr == `TFM_ADR_OUT_RELAY && reg_wdata[10:0] == 11'h3EB ##1 !reg_wr;
	endsequence

	relay_make_a: assert property (relay_no_closed == relay_coil)
		else $error("make contact differs from relay coil");
	relay_break_a: assert property (relay_nc_closed != relay_coil)
		else $error("break contact follows relay coil");
	run_excl_a: assert property (!(drive_forward && drive_reverse))
		else $error("forward and reverse driven together");
	stop_decel_a: assert property ((drive_forward || drive_reverse) != decel_to_stop)
		else $error("deceleration does not match run state");
	relay_inv_uv_a: assert property (s_relay_inv_uv |=> relay_coil == !$past(undervolt_stopped_flag))
		else $error("inverted undervoltage code not inverted on relay");
	relay_ready_a: assert property (relay_code_q == 11'h00A |=> relay_coil == $past(ready_to_drive))
		else $error("relay does not follow ready status");
	relay_uv_a: assert property (relay_code_q == 11'h003 |=> relay_coil == $past(undervolt_stopped_flag))
		else $error("relay does not follow undervoltage status");
	relay_undef_a: assert property (relay_code_q == 11'h009 || relay_code_q == 11'h3F1 |=> !relay_coil)
		else $error("undefined code drives relay");
	sync_mode_a: assert property (relay_code_q == 11'h01D && control_mode == 3'h0 |=> !relay_coil)
		else $error("phase lock shown in plain mode");
endmodule // tfm_checker

// >>> sim/tfm_ctrl_model.sv
// tfm_ctrl_model.sv: external controller that wires the input pins and reads the output terminals
// assumes one clock; pin requests come from the bench just after a rising edge
`timescale 1ns/10ps

module tfm_ctrl_model #(
	parameter MASK_CYC = 16
) (
	input wire ref_clk,
	input wire resetn,
	input wire [6:0] pin_req,
	output logic [6:0] din_pins,
	input wire [2:0] terms,
	output wire [2:0] terms_seen,
	output wire terms_valid
);
	// ==========================================================
	// pins and power-on mask
	int mask_cnt;

	// pins follow the request one edge later, as a controller output stage would
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			din_pins <= 7'h00;
		else
			din_pins <= pin_req;
	end

	// terminal states are not trusted during the power-on transient
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			mask_cnt <= 0;
		else if (mask_cnt < MASK_CYC)
			mask_cnt <= mask_cnt + 1;
	end

	// masked terminals read as off so nothing acts on them early
	assign terms_valid = (mask_cnt == MASK_CYC);
	assign terms_seen = terms_valid ? terms : 3'h0;
endmodule // tfm_ctrl_model

// >>> sim/tfm_top_tb.sv
// tfm_top_tb.sv: self-checking bench of the terminal function mapper
// assumes the checker and controller model files are compiled before this one
`timescale 1ns/10ps
`include "tfm_defs.vh"

module tfm_top_tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [6:0] pin_req = 7'h00;
	logic [2:0] control_mode = 3'h0, stage_number = 3'h0;
	logic [31:0] status_aux = 32'h00000000;
	logic undervolt_stopped_flag = 1'b0, motor_thermal_prewarn = 1'b0, ready_to_drive = 1'b0;
	logic fan_running = 1'b0, heatsink_overtemp_warning = 1'b0, phase_lock_done = 1'b0;
	wire [15:0] reg_rdata;
	wire [6:0] din_pins, logic_src;
	wire [1:0] speed_gain_set, pid_setpoint_sel;
	wire droop_enable, logic_engine_cancel, logic_timer_clear, regen_avoid_cancel, drive_forward, drive_reverse;
	wire decel_to_stop, transistor_out_one, transistor_out_two, relay_coil, relay_no_closed, relay_nc_closed;
	wire [2:0] terms_seen;
	wire terms_valid;
	wire [7:0] fn_vec = {droop_enable, speed_gain_set, logic_engine_cancel, logic_timer_clear,
		regen_avoid_cancel, pid_setpoint_sel};
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [15:0] rd_val;
	int codes[13] = '{0, 3, 7, 9, 10, 15, 18, 19, 20, 25, 28, 29, 31};
	logic [7:0] fn_code[9] = '{`TFM_FN_DROOP, `TFM_FN_GAIN_LO, `TFM_FN_GAIN_HI, `TFM_FN_LOGIC_CANCEL,
		`TFM_FN_TIMER_CLEAR, `TFM_FN_REGEN_CANCEL, `TFM_FN_PID_LO, `TFM_FN_PID_HI, `TFM_FN_NONE};
	logic [7:0] fn_exp[9] = '{8'h80, 8'h20, 8'h40, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02, 8'h00};

	// ==========================================================
	// clock, design and partner
	// 50 MHz reference clock
	always #10 ref_clk = ~ref_clk;

	tfm_top #(.NUM_IN(7)) tfm_top_inst (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.din_pins, .control_mode, .status_aux, .undervolt_stopped_flag, .motor_thermal_prewarn, .ready_to_drive,
		.stage_number, .fan_running, .heatsink_overtemp_warning, .phase_lock_done, .droop_enable, .speed_gain_set,
		.logic_engine_cancel, .logic_timer_clear, .regen_avoid_cancel, .pid_setpoint_sel, .drive_forward,
		.drive_reverse, .decel_to_stop, .logic_src, .transistor_out_one, .transistor_out_two, .relay_coil,
		.relay_no_closed, .relay_nc_closed);
	tfm_ctrl_model #(.MASK_CYC(16)) tfm_ctrl_model_inst (.ref_clk, .resetn, .pin_req, .din_pins,
		.terms({relay_coil, transistor_out_two, transistor_out_one}), .terms_seen, .terms_valid);

	// ==========================================================
	// tasks
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// synchroniser plus function register need about six edges; ten leaves margin
	task automatic pins(input logic [6:0] p);
		@(posedge ref_clk);
		pin_req <= p;
		tick(10);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// expected terminal level from the bench's own status pattern; undefined codes stay off
	function automatic logic exp_lvl(input int c);
		int b;
		logic v;
		b = (c >= 1000) ? c - 1000 : c;
		case (b)
			0, 15: v = status_aux[b];
			3: v = undervolt_stopped_flag;
			7: v = motor_thermal_prewarn;
			10: v = ready_to_drive;
			18: v = stage_number[0];
			19: v = stage_number[1];
			20: v = stage_number[2];
			25: v = fan_running;
			28: v = heatsink_overtemp_warning;
			29: v = phase_lock_done && (control_mode == 3'h1 || control_mode == 3'h2);
			default: return 1'b0;
		endcase
		return (c >= 1000) ? !v : v;
	endfunction

	// ==========================================================
	// test sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(8'(i));
			chk("input assign", rd_val, i < 5 ? 16'h0064 : (i == 5 ? 16'h0062 : 16'h0063));
		end
		for (int t = 0; t < 3; t++) begin
			rd(8'h10 + 8'(t));
			chk("output assign", rd_val, t == 0 ? 16'h0000 : (t == 1 ? 16'h0001 : 16'h000A));
		end
		rd(8'h7F);
		chk("unmapped read", rd_val, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			wr(8'h03, 16'(fn_code[i]));
			pins(7'h08);
			chk("function on", 16'(fn_vec), 16'(fn_exp[i]));
			chk("logic source", 16'(logic_src), 16'h0008);
			pins(7'h00);
			chk("function off", 16'(fn_vec), 16'h0000);
		end
		wr(8'h02, 16'h0062);
		rd(8'h02);
		chk("slot refusal", rd_val, 16'h0064);
		rd(`TFM_ADR_STATUS);
		chk("refusal flag", 16'(rd_val[15]), 16'h0001);
		wr(`TFM_ADR_CTRL, 16'h0001);
		rd(`TFM_ADR_STATUS);
		chk("flag cleared", 16'(rd_val[15]), 16'h0000);
		pins(7'h20);
		chk("run forward", 16'({drive_forward, drive_reverse, decel_to_stop}), 16'h0004);
		pins(7'h60);
		chk("run both", 16'({drive_forward, drive_reverse, decel_to_stop}), 16'h0001);
		pins(7'h40);
		chk("run reverse", 16'({drive_forward, drive_reverse, decel_to_stop}), 16'h0002);
		pins(7'h00);
		chk("run stop", 16'({drive_forward, drive_reverse, decel_to_stop}), 16'h0001);
		chk("mask over", 16'(terms_valid), 16'h0001);
		for (int p = 0; p < 3; p++) begin
			@(posedge ref_clk);
			status_aux <= (p % 2 == 0) ? 32'h00000001 : 32'hFFFFFFFE;
			undervolt_stopped_flag <= (p % 2 == 0);
			motor_thermal_prewarn <= (p % 2 == 1);
			ready_to_drive <= (p % 2 == 0);
			stage_number <= (p % 2 == 0) ? 3'h5 : 3'h2;
			fan_running <= (p % 2 == 0);
			heatsink_overtemp_warning <= (p % 2 == 1);
			phase_lock_done <= 1'b1;
			control_mode <= 3'(p);
			for (int i = 0; i < 13; i++)
				for (int pol = 0; pol < 2; pol++)
					for (int t = 0; t < 3; t++) begin
						wr(8'h10 + 8'(t), 16'(codes[i] + 1000 * pol));
						tick(2);
						chk("terminal level", 16'(terms_seen[t]), 16'(exp_lvl(codes[i] + 1000 * pol)));
					end
		end
		finish_test();
	end

	// hang guard sized well beyond the roughly 1250 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		finish_test();
	end
endmodule // tfm_top_tb

bind tfm_top tfm_checker #(.NUM_IN(NUM_IN)) tfm_checker_inst (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.control_mode, .undervolt_stopped_flag, .ready_to_drive, .drive_forward, .drive_reverse, .decel_to_stop,
	.relay_coil, .relay_no_closed, .relay_nc_closed);
